// File: hdl/brownout_reset_control_defines.vh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the brownout reset control design file only
`ifndef BROWNOUT_RESET_CONTROL_DEFINES_VH
`define BROWNOUT_RESET_CONTROL_DEFINES_VH

`define PERIPH_RESET_OFFSET    8'h0C
`define BROWNOUT_CTRL_OFFSET   8'h18
`define POR_KEY_OFFSET         8'h24
`define UNLOCK_OFFSET          8'hFC
`define TIMER_ZERO_RST_BIT     1
`define GPIO_RST_BIT           1
`define TIMER_RST_POS          2
`define GPIO_RST_POS           1
`define BROWNOUT_DETECTOR_ENABLE_POS             0
`define BROWNOUT_THRESHOLD_SELECT_LSB             1
`define BOD_RSTSEL_POS         3
`define BOD_FLAG_POS           4
`define BROWNOUT_LOW_POWER_SELECT_POS            5
`define BROWNOUT_COMPARE_STATUS_POS            6
`define LOW_VOLTAGE_RESET_ENABLE_POS             7
`define CFG_RSTSEL_POS         20
`define CFG_VL_LSB             21
`define CFG_EN_POS             23
`define UNLOCK_KEY0            8'h59
`define UNLOCK_KEY1            8'h16
`define UNLOCK_KEY2            8'h88
`define POR_DISABLE_KEY        16'h5AA5
`define POR_KEY_RESET          16'h0000
`define CLOCK_MHZ              10
`define LVR_SETTLE_US          100
`define LVR_SETTLE_CYCLES      11'h3E8

`endif

// File: hdl/brownout_reset_control.v
// Brownout detector, low-voltage reset, power-on-reset key and peripheral reset bits
// Assumes a synchronous register port, analog comparator levels and a config word
//
// Strobed register access was chosen for this implementation.
module brownout_reset_control (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrStb,
  input  wire        regRdStb,
  output reg  [31:0] regRdData,
  input  wire [31:0] userConfigWord,
  input  wire        brownoutCompareIn,
  input  wire        lowVoltageCompareIn,
  input  wire        otherChipResetSource,
  output reg         timerZeroResetOut,
  output reg         gpioResetOut,
  output reg         brownoutInterrupt,
  output reg         brownoutChipReset,
  output reg         lowVoltageChipReset,
  output reg         powerOnResetEnable,
  output reg         brownoutLowPowerOut,
  output reg  [1:0]  brownoutThresholdOut,
  output reg         brownoutDetectorOn
);

`include "brownout_reset_control_defines.vh"

  // ************************************************************
  // Registers
  // ************************************************************
  reg        timerZeroSoftReset_q;
  reg        gpioSoftReset_q;
  reg        lowVoltageResetEnable_q;
  reg        brownoutLowPowerSelect_q;
  reg        brownoutCrossingFlag_q;
  reg        brownoutResetSelect_q;
  reg  [1:0] brownoutThresholdSelect_q;
  reg        brownoutDetectorEnable_q;
  reg [15:0] powerOnResetDisableKey_q;
  reg        unlocked_q;
  reg  [2:0] unlockState_q;
  reg        cfgPending_q;
  reg        bodPrev_q;
  reg [10:0] lvrSettle_q;
  reg        lvrSettled_q;
  reg        bodIrqHold_q;
  reg [31:0] readNext_d;

  // ************************************************************
  // Unlock sequence states, one-hot
  // ************************************************************
  localparam [2:0] UNLOCK_IDLE   = 3'h1;
  localparam [2:0] UNLOCK_FIRST  = 3'h2;
  localparam [2:0] UNLOCK_SECOND = 3'h4;

  wire       writeCtrl;
  wire       periphWrite;
  wire       bodSynced;
  wire       lvrSynced;
  wire       writeKey;
  wire       writeUnlock;
  wire       brownoutCompareStatus;
  wire       crossing;
  wire [31:0] ctrlView;

  assign writeCtrl   = regWrStb && (regAddr == `BROWNOUT_CTRL_OFFSET);
  assign writeKey    = regWrStb && (regAddr == `POR_KEY_OFFSET);
  assign writeUnlock = regWrStb && (regAddr == `UNLOCK_OFFSET);
  assign periphWrite = regWrStb && (regAddr == `PERIPH_RESET_OFFSET);
  // Status masked by the enable
  assign brownoutCompareStatus = brownoutDetectorEnable_q & bodSynced;
  // Either-direction crossing of the synchronised comparator
  assign crossing = brownoutDetectorEnable_q & (bodSynced ^ bodPrev_q);
  assign ctrlView = {24'h000000, lowVoltageResetEnable_q, brownoutCompareStatus,
                     brownoutLowPowerSelect_q, brownoutCrossingFlag_q,
                     brownoutResetSelect_q, brownoutThresholdSelect_q,
                     brownoutDetectorEnable_q};

  // ************************************************************
  // Comparator synchronisers
  // ************************************************************
  brownout_level_sync #(
    .WIDTH (1)
  ) bod_level_sync_i (
    .clock   (clock),
    .sys_rst (sys_rst),
    .asyncIn (brownoutCompareIn),
    .syncOut (bodSynced)
  );

  brownout_level_sync #(
    .WIDTH (1)
  ) lvr_level_sync_i (
    .clock   (clock),
    .sys_rst (sys_rst),
    .asyncIn (lowVoltageCompareIn),
    .syncOut (lvrSynced)
  );

  // Previous synchronised level for crossing detection
  always @(posedge clock) begin
    if (sys_rst) begin
      bodPrev_q <= 1'b0;
    end else begin
      bodPrev_q <= bodSynced;
    end
  end

  // ************************************************************
  // Protection unlock sequence
  // ************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      unlockState_q <= UNLOCK_IDLE;
      unlocked_q    <= 1'b0;
    end else if (writeUnlock) begin
      // Three exact bytes in order open the gate; anything else locks
      case (unlockState_q)
        UNLOCK_IDLE: begin
          if (regWrData[7:0] == `UNLOCK_KEY0) begin
            unlockState_q <= UNLOCK_FIRST;
          end else begin
            unlocked_q <= 1'b0;
          end
        end
        UNLOCK_FIRST: begin
          if (regWrData[7:0] == `UNLOCK_KEY1) begin
            unlockState_q <= UNLOCK_SECOND;
          end else begin
            unlockState_q <= UNLOCK_IDLE;
            unlocked_q    <= 1'b0;
          end
        end
        UNLOCK_SECOND: begin
          unlockState_q <= UNLOCK_IDLE;
          unlocked_q    <= (regWrData[7:0] == `UNLOCK_KEY2);
        end
        default: begin
          unlockState_q <= UNLOCK_IDLE;
          unlocked_q    <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Control register fields
  // ************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      timerZeroSoftReset_q      <= 1'b0;
      gpioSoftReset_q           <= 1'b0;
      lowVoltageResetEnable_q   <= 1'b1;
      brownoutLowPowerSelect_q  <= 1'b0;
      brownoutResetSelect_q     <= 1'b0;
      brownoutThresholdSelect_q <= 2'h0;
      brownoutDetectorEnable_q  <= 1'b0;
      cfgPending_q              <= 1'b1;
      powerOnResetDisableKey_q  <= `POR_KEY_RESET;
    end else begin
      cfgPending_q <= 1'b0;
      if (cfgPending_q) begin
        // Configuration word caught after reset release
        brownoutResetSelect_q     <= userConfigWord[`CFG_RSTSEL_POS];
        brownoutThresholdSelect_q <= userConfigWord[`CFG_VL_LSB+1:`CFG_VL_LSB];
        brownoutDetectorEnable_q  <= userConfigWord[`CFG_EN_POS];
      end else if (writeCtrl && unlocked_q) begin
        lowVoltageResetEnable_q   <= regWrData[`LOW_VOLTAGE_RESET_ENABLE_POS];
        brownoutLowPowerSelect_q  <= regWrData[`BROWNOUT_LOW_POWER_SELECT_POS];
        brownoutResetSelect_q     <= regWrData[`BOD_RSTSEL_POS];
        brownoutThresholdSelect_q <= regWrData[`BROWNOUT_THRESHOLD_SELECT_LSB+1:`BROWNOUT_THRESHOLD_SELECT_LSB];
        brownoutDetectorEnable_q  <= regWrData[`BROWNOUT_DETECTOR_ENABLE_POS];
      end
      if (periphWrite) begin
        timerZeroSoftReset_q <= regWrData[`TIMER_RST_POS];
        gpioSoftReset_q      <= regWrData[`GPIO_RST_POS];
      end
      if (otherChipResetSource) begin
        powerOnResetDisableKey_q <= `POR_KEY_RESET;
      end else if (writeKey && unlocked_q) begin
        powerOnResetDisableKey_q <= regWrData[15:0];
      end
    end
  end

  // ************************************************************
  // Crossing flag, interrupt hold, settle timer
  // ************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      brownoutCrossingFlag_q <= 1'b0;
      bodIrqHold_q           <= 1'b0;
      lvrSettle_q            <= 11'h000;
      lvrSettled_q           <= 1'b0;
    end else begin
      // Set wins over the write-one clear
      if (crossing) begin
        brownoutCrossingFlag_q <= 1'b1;
      end else if (writeCtrl && regWrData[`BOD_FLAG_POS]) begin
        brownoutCrossingFlag_q <= 1'b0;
      end
      // Interrupt latches until the detector is disabled
      if (!brownoutDetectorEnable_q) begin
        bodIrqHold_q <= 1'b0;
      end else if (!brownoutResetSelect_q && (brownoutCompareStatus || crossing)) begin
        bodIrqHold_q <= 1'b1;
      end
      // Settle count restarts while disabled
      if (!lowVoltageResetEnable_q) begin
        lvrSettle_q <= 11'h000;
      end else if (lvrSettle_q != `LVR_SETTLE_CYCLES) begin
        lvrSettle_q <= lvrSettle_q + 11'h001;
      end
      // Settled only while the enable still stands
      lvrSettled_q <= lowVoltageResetEnable_q && (lvrSettle_q == `LVR_SETTLE_CYCLES);
    end
  end

  // ************************************************************
  // Outputs and read port
  // ************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      timerZeroResetOut    <= 1'b0;
      gpioResetOut         <= 1'b0;
      brownoutInterrupt    <= 1'b0;
      brownoutChipReset    <= 1'b0;
      lowVoltageChipReset  <= 1'b0;
      powerOnResetEnable   <= 1'b1;
      brownoutLowPowerOut  <= 1'b0;
      brownoutThresholdOut <= 2'h0;
      brownoutDetectorOn   <= 1'b0;
      regRdData            <= 32'h00000000;
    end else begin
      timerZeroResetOut    <= timerZeroSoftReset_q;
      gpioResetOut         <= gpioSoftReset_q;
      brownoutInterrupt    <= bodIrqHold_q & ~brownoutResetSelect_q;
      brownoutChipReset    <= brownoutCompareStatus & brownoutResetSelect_q;
      lowVoltageChipReset  <= lowVoltageResetEnable_q & lvrSynced & lvrSettled_q;
      powerOnResetEnable   <= (powerOnResetDisableKey_q != `POR_DISABLE_KEY);
      brownoutLowPowerOut  <= brownoutLowPowerSelect_q;
      brownoutThresholdOut <= brownoutThresholdSelect_q;
      brownoutDetectorOn   <= brownoutDetectorEnable_q;
      if (regRdStb) begin
        regRdData <= readNext_d;
      end else begin
        regRdData <= 32'h00000000;
      end
    end
  end

  // ************************************************************
  // Read data select
  // ************************************************************
  always @* begin
    readNext_d = 32'h00000000;
    case (regAddr)
      `PERIPH_RESET_OFFSET: begin
        readNext_d = {29'h00000000, timerZeroSoftReset_q, gpioSoftReset_q, 1'b0};
      end
      `BROWNOUT_CTRL_OFFSET: begin
        readNext_d = ctrlView;
      end
      `POR_KEY_OFFSET: begin
        readNext_d = {16'h0000, powerOnResetDisableKey_q};
      end
      `UNLOCK_OFFSET: begin
        readNext_d = {31'h00000000, unlocked_q};
      end
      default: begin
        readNext_d = 32'h00000000;
      end
    endcase
  end

endmodule // brownout_reset_control

// ************************************************************
// Two-flop level synchroniser
// ************************************************************
module brownout_level_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  // Only the second flop is read outside
  always @(posedge clock) begin
    if (sys_rst) begin
      stage1_q <= {WIDTH{1'b0}};
      stage2_q <= {WIDTH{1'b0}};
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule // brownout_level_sync

// File: bench/brownout_reset_control_monitor.sv
// Checker on the brownout reset control top ports
// Assumes one clock domain and the synchronous active-high reset
module brownout_reset_control_monitor (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic [31:0] userConfigWord,
  input wire logic        brownoutCompareIn,
  input wire logic        lowVoltageCompareIn,
  input wire logic        otherChipResetSource,
  input wire logic        timerZeroResetOut,
  input wire logic        gpioResetOut,
  input wire logic        brownoutInterrupt,
  input wire logic        brownoutChipReset,
  input wire logic        lowVoltageChipReset,
  input wire logic        powerOnResetEnable,
  input wire logic        brownoutLowPowerOut,
  input wire logic [1:0]  brownoutThresholdOut,
  input wire logic        brownoutDetectorOn
);
  // *****
  // Assertions
  // *****
  wire periphWr = regWrStb && regAddr == 8'h0C;
  wire keyWr    = regWrStb && regAddr == 8'h24 && regWrData[15:0] == 16'h5AA5;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_timer_reset_set: assert property (periphWr && regWrData[2] |-> ##[1:2] timerZeroResetOut)
    else $error("timer reset not raised");
  a_gpio_reset_clear: assert property (periphWr && !regWrData[1] |-> ##[1:2] !gpioResetOut)
    else $error("gpio reset not released");
  a_periph_reset_hold: assert property ($changed(timerZeroResetOut) || $changed(gpioResetOut)
    |-> $past(periphWr) || $past(periphWr, 2)) else $error("peripheral reset moved alone");
  a_status_off_zero: assert property (regRdStb && regAddr == 8'h18
    |=> (!brownoutDetectorOn |-> !regRdData[6])) else $error("status set while off");
  a_key_disable_cause: assert property ($fell(powerOnResetEnable)
    |-> $past(keyWr) || $past(keyWr, 2)) else $error("power-on reset off without key");
  a_key_restore_src: assert property (otherChipResetSource |-> ##[1:2] powerOnResetEnable)
    else $error("power-on reset not restored");
  a_irq_until_off: assert property ($fell(brownoutInterrupt) |-> ##[0:1] !brownoutDetectorOn)
    else $error("interrupt dropped while enabled");
  a_irq_not_reset: assert property (brownoutInterrupt |-> !brownoutChipReset)
    else $error("interrupt and chip reset together");
endmodule // brownout_reset_control_monitor

bind brownout_reset_control brownout_reset_control_monitor brownout_reset_control_monitor_i (.*);

// File: bench/brownout_reset_control_bench.sv
// Self-checking bench for the brownout reset control block
// Assumes the design file and the bound checker are compiled first
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module brownout_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, sys_rst, regWrStb, regRdStb, otherChipResetSource;
  logic        brownoutCompareIn, lowVoltageCompareIn, timerZeroResetOut, gpioResetOut;
  logic        brownoutInterrupt, brownoutChipReset, lowVoltageChipReset, powerOnResetEnable;
  logic        brownoutLowPowerOut, brownoutDetectorOn;
  logic [1:0]  brownoutThresholdOut;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData, userConfigWord, rdVal;
  int          err_count = 0;
  int          check_count = 0;
  brownout_reset_control brownout_reset_control_i (.*);
  // *****
  // Tasks
  // *****
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    @(negedge clock);
    rdVal = regRdData;
    if (n != "") `CHK(n, e, rdVal)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (4000) @(posedge clock);
    err_count++;
    test_done();
  end
  initial begin
    {regAddr, regWrData, regWrStb, regRdStb, brownoutCompareIn} = '0;
    {lowVoltageCompareIn, otherChipResetSource} = '0;
    userConfigWord = 32'h0050_0000;
    sys_rst = 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(2);
    rchk(8'h18, 32'h8C, "ctrl");
    `CHK("por", 1'b1, powerOnResetEnable)
    $display("test reset done");
    wr(8'h0C, 32'h6);
    `CHK("tmr", 1'b1, timerZeroResetOut)
    `CHK("gpio", 1'b1, gpioResetOut)
    wr(8'h0C, 32'h4);
    `CHK("gpio", 1'b0, gpioResetOut)
    `CHK("tmr", 1'b1, timerZeroResetOut)
    wr(8'h0C, 32'h0);
    `CHK("tmr", 1'b0, timerZeroResetOut)
    $display("test periph done");
    wr(8'h18, 32'h81);
    rchk(8'h18, 32'h8C, "ctrl");
    wr(8'h24, 32'h5AA5);
    `CHK("por", 1'b1, powerOnResetEnable)
    rchk(8'h40, 32'h0, "unmapped");
    wr(8'hFC, 32'h59);
    wr(8'hFC, 32'h16);
    wr(8'hFC, 32'h88);
    rchk(8'hFC, 32'h1, "unlock");
    for (int v = 0; v < 4; v++) begin
      wr(8'h18, 32'hA1 | (v << 1));
      `CHK("thr", v[1:0], brownoutThresholdOut)
    end
    rchk(8'h18, 32'hA7, "ctrl");
    `CHK("lpm", 1'b1, brownoutLowPowerOut)
    `CHK("on", 1'b1, brownoutDetectorOn)
    $display("test unlock done");
    @(posedge clock) brownoutCompareIn <= 1'b1;
    cyc(5);
    rchk(8'h18, 32'hF7, "fall");
    `CHK("irq", 1'b1, brownoutInterrupt)
    wr(8'h18, 32'hB7);
    rchk(8'h18, 32'hE7, "w1c");
    @(posedge clock) brownoutCompareIn <= 1'b0;
    cyc(5);
    rchk(8'h18, 32'hB7, "rise");
    `CHK("irq", 1'b1, brownoutInterrupt)
    wr(8'h18, 32'hA7);
    rchk(8'h18, 32'hB7, "w0");
    wr(8'h18, 32'hA6);
    @(negedge clock);
    `CHK("irq", 1'b0, brownoutInterrupt)
    @(posedge clock) brownoutCompareIn <= 1'b1;
    cyc(5);
    rchk(8'h18, 32'h0, "");
    `CHK("off", 1'b0, rdVal[6])
    wr(8'h18, 32'h89);
    `CHK("bodrst", 1'b1, brownoutChipReset)
    @(posedge clock) brownoutCompareIn <= 1'b0;
    cyc(5);
    `CHK("bodrst", 1'b0, brownoutChipReset)
    $display("test detector done");
    wr(8'h24, 32'h5AA5);
    `CHK("por", 1'b0, powerOnResetEnable)
    rchk(8'h24, 32'h5AA5, "key");
    wr(8'h24, 32'h1234);
    `CHK("por", 1'b1, powerOnResetEnable)
    wr(8'h24, 32'h5AA5);
    @(posedge clock) otherChipResetSource <= 1'b1;
    @(posedge clock) otherChipResetSource <= 1'b0;
    cyc(2);
    `CHK("por", 1'b1, powerOnResetEnable)
    $display("test key done");
    wr(8'h18, 32'h0);
    wr(8'h18, 32'h80);
    @(posedge clock) lowVoltageCompareIn <= 1'b1;
    cyc(900);
    `CHK("lvr", 1'b0, lowVoltageChipReset)
    cyc(200);
    `CHK("lvr", 1'b1, lowVoltageChipReset)
    @(posedge clock) lowVoltageCompareIn <= 1'b0;
    wr(8'hFC, 32'h0);
    rchk(8'hFC, 32'h0, "relock");
    wr(8'h18, 32'h91);
    rchk(8'h18, 32'h80, "ctrl");
    $display("test lvr done");
    test_done();
  end
endmodule // brownout_reset_control_bench
